// ---- dpst_host_model.sv ----
`timescale 1ns/1ps
module dpst_host_model (
  input  wire logic mclk,
  input  wire logic sdo_o,
  input  wire logic sdo_oe,
  output logic      sclk,
  output logic      sync_n,
  output logic      sdi
);
  // 400 ns serial clock, slow enough for readback
  localparam int HALF = 4;

  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdi = 1'b0;
  end

  // Clock idles high so each frame opens on a falling edge
  task automatic xfer(input logic [23:0] w, input int n,
                      output logic [23:0] rx);
    rx = 24'h000000;
    repeat (6) @(negedge mclk);
    sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = w[23 - (i % 24)];
      repeat (HALF) @(negedge mclk);
      sclk = 1'b0;
      rx = {rx[22:0], sdo_oe ? sdo_o : 1'bx};
      repeat (HALF) @(negedge mclk);
      sclk = 1'b1;
    end
    repeat (HALF) @(negedge mclk);
    sync_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule

// ---- dpst_pkg.sv ----
package dpst_pkg;

  typedef enum logic [1:0] {
    DPST_IDLE  = 2'b00,
    DPST_BUSY  = 2'b01,
    DPST_RESP  = 2'b10,
    DPST_RESET = 2'b11
  } dpst_state_t;

  typedef struct packed {
    logic [6:0]  addr;
    logic [15:0] data;
  } dpst_word_t;

  typedef struct packed {
    logic [15:0] level;
    logic [2:0]  range;
  } dpst_setting_t;

endpackage

// ---- dpst_regs.svh ----
`ifndef DPST_REGS_SVH
`define DPST_REGS_SVH

// ----------------------------------------------------------------
// Frame and word layout
// ----------------------------------------------------------------
`define DPST_WORD_BITS      24
`define DPST_ADDR_MSB       23
`define DPST_ADDR_LSB       16
`define DPST_DATA_MSB       15
`define DPST_DATA_LSB       0
`define DPST_BITCNT_W       5
`define DPST_BITCNT_FULL    5'h18
`define DPST_BITCNT_OVER    5'h19
`define DPST_BITCNT_ZERO    5'h00
`define DPST_RD_FLAG_BIT    23
`define DPST_ADDR_PRIMARY   7'h08
`define DPST_ADDR_RANGE     7'h03
`define DPST_RANGE_LSB      0
`define DPST_RANGE_MSB      2

// ----------------------------------------------------------------
// Timing, in nanoseconds, and derived mclk cycle counts
// ----------------------------------------------------------------
`define DPST_MCLK_NS        50
`define DPST_BUSY_PRI_NS    1500
`define DPST_BUSY_OTH_NS    280
`define DPST_RESET_BUSY_NS  400000
`define DPST_RESP_NS        150
`define DPST_BUSY_PRI_CYC   (`DPST_BUSY_PRI_NS / `DPST_MCLK_NS)
`define DPST_BUSY_OTH_CYC   (`DPST_BUSY_OTH_NS / `DPST_MCLK_NS)
`define DPST_RESET_BUSY_CYC (`DPST_RESET_BUSY_NS / `DPST_MCLK_NS)
`define DPST_RESP_CYC       (`DPST_RESP_NS / `DPST_MCLK_NS)
`define DPST_CNT_W          14
`define DPST_CNT_ZERO       14'h0000
`define DPST_CNT_ONE        14'h0001

`endif

// ---- dpst_serial_port.sv ----
`timescale 1ns/1ps
`include "dpst_regs.svh"
// Summary of operation
// [R1] The host frames each write word with exactly 24 falling clock edges.
// [R2] A write to the primary force level holds busy low at most 1.5 us.
// [R3] A write to any other register holds busy low at most 280 ns.
// [R4] After a hardware reset busy stays low at most 400 us.
// [R5] The host holds the reset input low at least 25 ns.
// [R6] The host keeps frame select high 250 ns after a readback request.
// [R7] Readback bits change after a rising clock edge, valid within 45 ns; here they change on the third mclk edge after the rise, 100 to 150 ns.
// [R8] The data output goes to high impedance within 30 ns of frame end; here it takes two mclk edges through the synchroniser, 50 to 100 ns.
// [R9] The host waits for busy high before pulling load low.
// [R10] The host holds load low at least 20 ns.
// [R11] Load rising edge applies staged level and range about 150 ns later.
// [R12] Without load hold-off the force output follows 150 ns after busy.
// [R13] A whole channel update completes within 600 ns of the word; here a primary write takes 1.5 us busy plus 150 ns.
// [R14] The host slows the serial clock for readback.
// [R15] The host keeps the serial clock period at least 20 ns, 60/40 duty.
// [R16] The host lowers frame select before the first falling clock edge.
// [R17] Input is sampled on falling edges while framed, msb first.
module dpst_serial_port (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   sclk,
  input  wire logic                   sync_n,
  input  wire logic                   sdi,
  input  wire logic                   hw_reset_n,
  input  wire logic                   load_n,
  input  wire logic                   hold_for_load,
  output logic                        sdo_o,
  output logic                        sdo_oe,
  output logic                        busy_n,
  output dpst_pkg::dpst_setting_t     applied,
  output logic [15:0]                 reg_addr_wr,
  output logic                        reg_wr_stb
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] meta_ff;
  logic [4:0] sync_ff;
  logic [4:0] prev_ff;
  logic [4:0] nxt_meta;
  logic [4:0] nxt_sync;

  always_comb begin
    nxt_meta = {sclk, sync_n, sdi, hw_reset_n, load_n};
    nxt_sync = meta_ff;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff <= 5'h1f;
      sync_ff <= 5'h1f;
      prev_ff <= 5'h1f;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= sync_ff;
    end
  end

  logic s_sclk, s_sync_n, s_sdi, s_rst_n, s_load_n;
  assign {s_sclk, s_sync_n, s_sdi, s_rst_n, s_load_n} = sync_ff;
  logic sclk_fall, sclk_rise, sync_rise, rst_rise, load_rise;
  assign sclk_fall = prev_ff[4] & ~s_sclk;
  assign sclk_rise = ~prev_ff[4] & s_sclk;
  assign sync_rise = ~prev_ff[3] & s_sync_n;
  assign rst_rise  = ~prev_ff[1] & s_rst_n;
  assign load_rise = ~prev_ff[0] & s_load_n;

  // ----------------------------------------------------------------
  // Shift register and readback
  // ----------------------------------------------------------------
  // Readback needs the slower serial clock the host promises, since
  // edges are found by sampling; a fast clock would be missed.
  logic [23:0]                 shift_ff, nxt_shift;
  logic [`DPST_BITCNT_W-1:0]   bitcnt_ff, nxt_bitcnt;
  logic [23:0]                 rdsh_ff, nxt_rdsh;
  logic                        rdmode_ff, nxt_rdmode;
  logic                        oe_ff, nxt_oe;
  logic                        word_done;
  dpst_pkg::dpst_word_t        word;
  dpst_pkg::dpst_setting_t     staged_ff, nxt_staged;
  dpst_pkg::dpst_setting_t     applied_ff, nxt_applied;

  assign word = {shift_ff[`DPST_ADDR_MSB-1:`DPST_ADDR_LSB],
                 shift_ff[`DPST_DATA_MSB:`DPST_DATA_LSB]};
  // Count saturates one past a word, so 48 falls never pass as 24
  assign word_done = sync_rise & (bitcnt_ff == `DPST_BITCNT_FULL); // R1

  // Range decode is shared by readback and staging
  function automatic logic dpst_is_range(input logic [6:0] a);
    return a == `DPST_ADDR_RANGE;
  endfunction

  always_comb begin
    nxt_shift  = shift_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_rdsh   = rdsh_ff;
    nxt_rdmode = rdmode_ff;
    nxt_oe     = oe_ff;
    if (s_sync_n) begin
      nxt_bitcnt = `DPST_BITCNT_ZERO;
      nxt_oe     = 1'b0; // R8
    end else begin
      nxt_oe = rdmode_ff;
      if (sclk_fall) begin // R17
        nxt_shift = {shift_ff[22:0], s_sdi};
        if (bitcnt_ff != `DPST_BITCNT_OVER) begin
          nxt_bitcnt = bitcnt_ff + 5'h01;
        end
      end
      if (sclk_rise && rdmode_ff) begin
        nxt_rdsh = {rdsh_ff[22:0], 1'b0}; // R7
      end
    end
    if (word_done) begin
      nxt_rdmode = shift_ff[`DPST_RD_FLAG_BIT];
      nxt_rdsh   = {shift_ff[`DPST_ADDR_MSB:`DPST_ADDR_LSB],
                    dpst_is_range(word.addr) ?
                    {13'h0000, staged_ff.range} : staged_ff.level};
    end else if (sync_rise) begin
      nxt_rdmode = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shift_ff  <= 24'h000000;
      bitcnt_ff <= `DPST_BITCNT_ZERO;
      rdsh_ff   <= 24'h000000;
      rdmode_ff <= 1'b0;
      oe_ff     <= 1'b0;
    end else begin
      shift_ff  <= nxt_shift;
      bitcnt_ff <= nxt_bitcnt;
      rdsh_ff   <= nxt_rdsh;
      rdmode_ff <= nxt_rdmode;
      oe_ff     <= nxt_oe;
    end
  end

  // Output enable drops combinationally with the synced frame end
  assign sdo_oe = oe_ff & ~s_sync_n; // R8
  assign sdo_o  = rdsh_ff[23];

  // ----------------------------------------------------------------
  // Busy and apply sequencer
  // ----------------------------------------------------------------
  dpst_pkg::dpst_state_t       st_ff, nxt_st;
  logic [`DPST_CNT_W-1:0]      cnt_ff, nxt_cnt;
  logic                        wstb_ff, nxt_wstb;
  logic [15:0]                 waddr_ff, nxt_waddr;
  logic                        write_ev;

  assign write_ev = word_done & ~shift_ff[`DPST_RD_FLAG_BIT];

  function automatic logic dpst_cnt_end(input logic [`DPST_CNT_W-1:0] c);
    return c == `DPST_CNT_ONE;
  endfunction

  always_comb begin
    nxt_st      = st_ff;
    nxt_cnt     = cnt_ff;
    nxt_staged  = staged_ff;
    nxt_applied = applied_ff;
    nxt_wstb    = 1'b0;
    nxt_waddr   = waddr_ff;
    if (load_rise && !hold_for_load) begin
      nxt_applied = staged_ff;
    end
    unique case (st_ff)
      dpst_pkg::DPST_IDLE: begin
        if (write_ev) begin
          nxt_wstb  = 1'b1;
          nxt_waddr = {9'h000, word.addr};
          if (word.addr == `DPST_ADDR_PRIMARY) begin
            nxt_staged.level = word.data;
            nxt_cnt = `DPST_CNT_W'(`DPST_BUSY_PRI_CYC); // R2
          end else begin
            if (dpst_is_range(word.addr)) begin
              nxt_staged.range =
                word.data[`DPST_RANGE_MSB:`DPST_RANGE_LSB];
            end
            nxt_cnt = `DPST_CNT_W'(`DPST_BUSY_OTH_CYC); // R3
          end
          nxt_st = dpst_pkg::DPST_BUSY;
        end
      end
      dpst_pkg::DPST_BUSY: begin
        if (dpst_cnt_end(cnt_ff)) begin
          nxt_cnt = `DPST_CNT_W'(`DPST_RESP_CYC); // R12
          nxt_st  = hold_for_load ? dpst_pkg::DPST_IDLE
                                  : dpst_pkg::DPST_RESP;
        end else begin
          nxt_cnt = cnt_ff - `DPST_CNT_ONE;
        end
      end
      dpst_pkg::DPST_RESP: begin
        if (dpst_cnt_end(cnt_ff)) begin
          nxt_applied = nxt_staged; // R13
          nxt_st      = dpst_pkg::DPST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - `DPST_CNT_ONE;
        end
      end
      dpst_pkg::DPST_RESET: begin
        if (dpst_cnt_end(cnt_ff)) begin
          nxt_st = dpst_pkg::DPST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - `DPST_CNT_ONE;
        end
      end
    endcase
    // Load applies the staged pair when the host holds updates back
    if (load_rise && hold_for_load) begin
      nxt_applied = staged_ff; // R11
    end
    if (rst_rise) begin
      nxt_staged  = '0;
      nxt_applied = '0;
      nxt_cnt     = `DPST_CNT_W'(`DPST_RESET_BUSY_CYC); // R4
      nxt_st      = dpst_pkg::DPST_RESET;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff      <= dpst_pkg::DPST_IDLE;
      cnt_ff     <= `DPST_CNT_ZERO;
      staged_ff  <= '0;
      applied_ff <= '0;
      wstb_ff    <= 1'b0;
      waddr_ff   <= 16'h0000;
    end else begin
      st_ff      <= nxt_st;
      cnt_ff     <= nxt_cnt;
      staged_ff  <= nxt_staged;
      applied_ff <= nxt_applied;
      wstb_ff    <= nxt_wstb;
      waddr_ff   <= nxt_waddr;
    end
  end

  assign busy_n      = ~((st_ff == dpst_pkg::DPST_BUSY) |
                         (st_ff == dpst_pkg::DPST_RESET));
  assign applied     = applied_ff;
  assign reg_addr_wr = waddr_ff;
  assign reg_wr_stb  = wstb_ff;

endmodule

// ---- dpst_sp_asserts.sv ----
`timescale 1ns/1ps
module dpst_sp_asserts (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        sclk,
  input wire logic        sync_n,
  input wire logic        hw_reset_n,
  input wire logic        sdo_o,
  input wire logic        sdo_oe,
  input wire logic        busy_n,
  input wire logic [15:0] reg_addr_wr,
  input wire logic        reg_wr_stb
);
  logic [13:0] low_ff;
  logic [13:0] nxt_low;

  always_comb begin
    nxt_low = busy_n ? 14'h0000 : low_ff + 14'h0001;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_ff <= 14'h0000;
    end else begin
      low_ff <= nxt_low;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence pri_run;
    ##29 !busy_n ##1 busy_n;
  endsequence
  sequence oth_run;
    !busy_n [*5] ##1 busy_n;
  endsequence

  a_stb_busy_low: assert property (reg_wr_stb |-> !busy_n)
    else $error("busy not low with write strobe");
  a_pri_busy_len: assert property (
    reg_wr_stb && reg_addr_wr == 16'h0008 |-> pri_run)
    else $error("primary busy length wrong");
  a_oth_busy_len: assert property (
    reg_wr_stb && reg_addr_wr != 16'h0008 |-> oth_run)
    else $error("other busy length wrong");
  a_rst_busy_start: assert property (
    $rose(hw_reset_n) |-> ##[1:6] !busy_n)
    else $error("no busy after reset pin");
  a_busy_cap_len: assert property (low_ff <= 14'h1f40)
    else $error("busy low too long");
  a_sdo_release: assert property ($rose(sync_n) |-> ##[1:5] !sdo_oe)
    else $error("sdo not released");
  a_sdo_after_rise: assert property (
    sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> sclk)
    else $error("sdo changed outside high clock");
  a_stb_framed: assert property (
    reg_wr_stb |-> sync_n ##1 !reg_wr_stb)
    else $error("write strobe out of frame");
endmodule

bind dpst_serial_port dpst_sp_asserts u_chk (
  .mclk(mclk), .rst(rst), .sclk(sclk), .sync_n(sync_n),
  .hw_reset_n(hw_reset_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
  .busy_n(busy_n), .reg_addr_wr(reg_addr_wr), .reg_wr_stb(reg_wr_stb)
);

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  logic                    mclk;
  logic                    rst;
  logic                    sclk;
  logic                    sync_n;
  logic                    sdi;
  logic                    hw_reset_n;
  logic                    load_n;
  logic                    hold_for_load;
  logic                    sdo_o;
  logic                    sdo_oe;
  logic                    busy_n;
  logic                    reg_wr_stb;
  logic [15:0]             reg_addr_wr;
  logic [23:0]             rx;
  dpst_pkg::dpst_setting_t applied;
  int                      err_total = 0;
  int                      n_checks = 0;
  int                      n;

  dpst_serial_port dut (.mclk(mclk), .rst(rst), .sclk(sclk),
    .sync_n(sync_n), .sdi(sdi), .hw_reset_n(hw_reset_n),
    .load_n(load_n), .hold_for_load(hold_for_load), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe), .busy_n(busy_n), .applied(applied),
    .reg_addr_wr(reg_addr_wr), .reg_wr_stb(reg_wr_stb));
  dpst_host_model host (.mclk(mclk), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .sclk(sclk), .sync_n(sync_n), .sdi(sdi));

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("ERROR %0t count %0d out of range", $time, got);
    end
  endtask
  // Bounded: waits for busy to fall, then counts its low cycles
  task automatic busy_len(output int c);
    int k;
    k = 0;
    c = 0;
    while (busy_n === 1'b1 && k < 40) begin
      @(negedge mclk);
      k++;
    end
    while (busy_n !== 1'b1 && c < 9000) begin
      @(negedge mclk);
      c++;
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_primary;
    hold_for_load = 1'b0;
    host.xfer({1'b0, 7'h08, 16'h1234}, 24, rx);
    busy_len(n);
    chk_rng(n, 1, 30);
    chk({8'h00, reg_addr_wr}, 24'h000008);
    repeat (4) @(negedge mclk);
    chk({8'h00, applied.level}, 24'h001234);
  endtask
  task automatic t_load;
    hold_for_load = 1'b1;
    host.xfer({1'b0, 7'h03, 16'h0005}, 24, rx);
    busy_len(n);
    chk_rng(n, 1, 5);
    repeat (6) @(negedge mclk);
    chk({21'h000000, applied.range}, 24'h000000);
    load_n = 1'b0;
    @(negedge mclk);
    load_n = 1'b1;
    repeat (6) @(negedge mclk);
    chk({21'h000000, applied.range}, 24'h000005);
  endtask
  task automatic t_short;
    host.xfer({1'b0, 7'h08, 16'h0bad}, 23, rx);
    repeat (12) @(negedge mclk);
    chk({23'h000000, busy_n}, 24'h000001);
    chk({8'h00, reg_addr_wr}, 24'h000003);
    host.xfer({1'b0, 7'h08, 16'h0bad}, 48, rx);
    repeat (12) @(negedge mclk);
    chk({23'h000000, busy_n}, 24'h000001);
    chk({8'h00, reg_addr_wr}, 24'h000003);
  endtask
  task automatic t_read;
    host.xfer({1'b1, 7'h03, 16'h0000}, 24, rx);
    busy_len(n);
    host.xfer(24'h000000, 24, rx);
    chk(rx, {1'b1, 7'h03, 16'h0005});
    repeat (5) @(negedge mclk);
    chk({23'h000000, sdo_oe}, 24'h000000);
    busy_len(n);
    host.xfer({1'b1, 7'h08, 16'h0000}, 24, rx);
    busy_len(n);
    host.xfer(24'h000000, 24, rx);
    chk(rx, {1'b1, 7'h08, 16'h1234});
    busy_len(n);
    chk_rng(n, 1, 5);
  endtask
  task automatic t_hwrst;
    hw_reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    hw_reset_n = 1'b1;
    busy_len(n);
    chk_rng(n, 1, 8000);
    chk({5'h00, applied}, 24'h000000);
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    hw_reset_n = 1'b1;
    load_n = 1'b1;
    hold_for_load = 1'b0;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    t_primary();
    t_load();
    t_short();
    t_read();
    t_hwrst();
    wrap_up();
  end
  initial begin
    #2000000;
    err_total++;
    wrap_up();
  end
endmodule
